// [design/dtp_pkg.sv]
// constants and carrier types for the dual 10-bit timer / pwm pair
// Contract
// - each channel: 10-bit down counter behind its own programmable prescaler
// - when running, buffered reload enters the counter only at the next underflow
// - when stopped, writing the low reload byte loads the counter at once
// - reading a channel's count gives the live counter, not the reload buffer
// - first control bit 0 runs the counter when set, stops it when clear
// - second control bit 5 picks external input (1) or instruction clock (0)
// - second control bit 4 picks falling (1) or rising (0) external edge
// - prescaler active when second control bit 3 is 0, ratio from bits 2:0
// - prescaler current count is readable per channel
// - one-shot mode (first control bit 2) counts down once then underflows
// - non-stop with reload select set restarts from the stored reload value
// - non-stop with reload select clear restarts from 0x3FF
// - underflow sets flag bit 4 (channel a) or bit 5 (channel b)
// - request when flag, its enable (bit 0 or 1) and global enable are all set
// - underflow flag stays set until software writes 0 to it
// - first control bit 7 routes pwm to the pin and forces it to output
// - first control bit 6 makes the pwm output active low
// - duty value zero keeps the pwm output inactive forever
// - pwm active for duty-value timer input clocks per frame
// - duty written high bits first; new duty applied after next underflow
package dtp_pkg;

    localparam int          DTP_NUM_CH      = 2;
    localparam int          DTP_CNT_W       = 10;
    localparam int          DTP_DIV_W       = 8;
    localparam int          DTP_RATIO_W     = 3;
    localparam int          DTP_INSTR_DIV   = 1;

    localparam logic [9:0]  DTP_CNT_ALL_ONES = 10'h3FF;
    localparam logic [9:0]  DTP_CNT_ZERO     = 10'h000;
    localparam logic [9:0]  DTP_COUNT_RST    = 10'h3FF;
    localparam logic [9:0]  DTP_RELOAD_RST   = 10'h3FF;
    localparam logic [9:0]  DTP_DUTY_RST     = 10'h000;
    localparam logic [7:0]  DTP_HIGH_RST     = 8'h00;
    localparam logic [7:0]  DTP_DIV_RST      = 8'h00;

    // shared high register: duty bits low, reload bits high
    localparam int          DTP_HI_DUTY_LSB_A = 0;
    localparam int          DTP_HI_DUTY_LSB_B = 2;
    localparam int          DTP_HI_RLD_LSB_A  = 4;
    localparam int          DTP_HI_RLD_LSB_B  = 6;

    // second interrupt register image
    localparam int          DTP_IRQ_EN_POS_A   = 0;
    localparam int          DTP_IRQ_EN_POS_B   = 1;
    localparam int          DTP_IRQ_FLAG_POS_A = 4;
    localparam int          DTP_IRQ_FLAG_POS_B = 5;

    typedef struct packed {
        logic       wave_out_enable;
        logic       wave_active_low;
        logic [2:0] unused;
        logic       single_shot;
        logic       reload_select;
        logic       run_enable;
    } dtp_ctrl_first_t;

    typedef struct packed {
        logic [1:0] unused;
        logic       source_select;
        logic       edge_select;
        logic       divider_enable_n;
        logic [2:0] divider_ratio;
    } dtp_ctrl_second_t;

    typedef struct packed {
        logic [9:0] count;
        logic [7:0] divider_count;
        logic       underflow_flag;
        logic       wave;
        logic       wave_oe;
    } dtp_status_t;

endpackage

// [design/dtp_prescaler.sv]
// programmable power-of-two prescaler for one timer channel
`timescale 1ns/1ns
module dtp_prescaler
    import dtp_pkg::*;
#(
    parameter int DIV_W   = DTP_DIV_W,
    parameter int RATIO_W = DTP_RATIO_W
) (
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    // control
    input  wire logic               run_i,
    input  wire logic               enable_n_i,
    input  wire logic [RATIO_W-1:0] ratio_i,
    // ticks
    input  wire logic               tick_i,
    output logic                    tick_o,
    output logic [DIV_W-1:0]        count_o
);

    logic [DIV_W-1:0] count_reg;
    logic [DIV_W-1:0] last;

    // code n divides by 2^(n+1)
    assign last = DIV_W'((32'd2 << ratio_i) - 32'd1);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_reg <= DTP_DIV_RST;
        end else if (!run_i || enable_n_i) begin
            count_reg <= DTP_DIV_RST;
        end else if (tick_i) begin
            count_reg <= (count_reg == last) ? DTP_DIV_RST : count_reg + 1'b1;
        end
    end

    // bypassed prescaler passes every source tick
    assign tick_o  = tick_i && (enable_n_i || count_reg == last);
    assign count_o = count_reg;

endmodule

// [design/dtp_timer_pair.sv]
// dual 10-bit down-count timer with prescalers and pwm outputs
`timescale 1ns/1ns
module dtp_timer_pair
    import dtp_pkg::*;
#(
    parameter int NUM_CH    = DTP_NUM_CH,
    parameter int CNT_W     = DTP_CNT_W,
    parameter int DIV_W     = DTP_DIV_W,
    parameter int INSTR_DIV = DTP_INSTR_DIV
) (
    // clock and reset
    input  wire logic                          REF_CLK_I,
    input  wire logic                          RST_N_I,
    // external count pin
    input  wire logic                          EXT_COUNT_I,
    // shared high bits register write
    input  wire logic                          HIGH_WR_I,
    input  wire logic [7:0]                    HIGH_DATA_I,
    // low byte writes, one strobe per channel
    input  wire logic [NUM_CH-1:0]             RELOAD_WR_I,
    input  wire logic [NUM_CH-1:0]             DUTY_WR_I,
    input  wire logic [7:0]                    WR_DATA_I,
    // control registers
    input  wire dtp_ctrl_first_t  [NUM_CH-1:0] CTRL_FIRST_I,
    input  wire dtp_ctrl_second_t [NUM_CH-1:0] CTRL_SECOND_I,
    // interrupt control
    input  wire logic [NUM_CH-1:0]             IRQ_ENABLE_I,
    input  wire logic                          GLOBAL_IRQ_ENABLE_I,
    input  wire logic [NUM_CH-1:0]             FLAG_CLEAR_I,
    // status
    output dtp_status_t [NUM_CH-1:0]           STATUS_O,
    output logic [7:0]                         HIGH_BITS_O,
    output logic [7:0]                         IRQ_REG_O,
    output logic                               IRQ_REQ_O
);

    ////////////////////////////////////////////////////////////////////////
    // instruction clock enable

    localparam int DIV_CW = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;

    logic [DIV_CW-1:0] instr_cnt_reg;
    logic              instr_tick;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            instr_cnt_reg <= '0;
        end else if (instr_cnt_reg == DIV_CW'(INSTR_DIV - 1)) begin
            instr_cnt_reg <= '0;
        end else begin
            instr_cnt_reg <= instr_cnt_reg + 1'b1;
        end
    end

    // divide of one means every reference edge
    assign instr_tick = (INSTR_DIV <= 1) || (instr_cnt_reg == DIV_CW'(INSTR_DIV - 1));

    ////////////////////////////////////////////////////////////////////////
    // external pin edges

    logic ext_prev_reg;
    logic ext_rise;
    logic ext_fall;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ext_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= EXT_COUNT_I;
        end
    end

    assign ext_rise = EXT_COUNT_I && !ext_prev_reg;
    assign ext_fall = !EXT_COUNT_I && ext_prev_reg;

    ////////////////////////////////////////////////////////////////////////
    // shared high bits register

    logic [7:0] high_reg;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            high_reg <= DTP_HIGH_RST;
        end else if (HIGH_WR_I) begin
            high_reg <= HIGH_DATA_I;
        end
    end

    assign HIGH_BITS_O = high_reg;

    ////////////////////////////////////////////////////////////////////////
    // channels

    logic [NUM_CH-1:0] flags;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
            localparam int RLD_LSB  = (ch == 0) ? DTP_HI_RLD_LSB_A : DTP_HI_RLD_LSB_B;
            localparam int DUTY_LSB = (ch == 0) ? DTP_HI_DUTY_LSB_A : DTP_HI_DUTY_LSB_B;

            dtp_ctrl_first_t  c1;
            dtp_ctrl_second_t c2;
            logic             src_tick;
            logic             cnt_tick;
            logic             run;
            logic             step;
            logic             underflow;
            logic             load_now;
            logic [CNT_W-1:0] wr_value;
            logic [CNT_W-1:0] count_reg;
            logic [CNT_W-1:0] reload_reg;
            logic [CNT_W-1:0] duty_buf_reg;
            logic [CNT_W-1:0] duty_act_reg;
            logic             done_reg;
            logic             flag_reg;
            logic [DIV_W-1:0] div_count;
            logic             wave;
            logic             wave_oe;

            assign c1 = CTRL_FIRST_I[ch];
            assign c2 = CTRL_SECOND_I[ch];

            // source pick: instruction clock or chosen pin edge
            assign src_tick = c2.source_select ? (c2.edge_select ? ext_fall : ext_rise)
                                               : instr_tick;

            // one-shot stops after its single pass until rearmed
            assign run = c1.run_enable && !done_reg;

            dtp_prescaler #(
                .DIV_W   (DIV_W),
                .RATIO_W (DTP_RATIO_W)
            ) u_prescaler (
                .clk_i      (REF_CLK_I),
                .rst_n_i    (RST_N_I),
                .run_i      (run),
                .enable_n_i (c2.divider_enable_n),
                .ratio_i    (c2.divider_ratio),
                .tick_i     (src_tick),
                .tick_o     (cnt_tick),
                .count_o    (div_count)
            );

            assign step      = run && cnt_tick;
            assign underflow = step && (count_reg == DTP_CNT_ZERO);

            // upper bits must already sit in the high register
            assign wr_value  = {high_reg[RLD_LSB +: 2], WR_DATA_I};
            assign load_now  = RELOAD_WR_I[ch] && !c1.run_enable;

            // reload buffer, double-buffered against the counter
            always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
                if (!RST_N_I) begin
                    reload_reg <= DTP_RELOAD_RST;
                end else if (RELOAD_WR_I[ch]) begin
                    reload_reg <= wr_value;
                end
            end

            always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
                if (!RST_N_I) begin
                    count_reg <= DTP_COUNT_RST;
                end else if (load_now) begin
                    count_reg <= wr_value;
                end else if (underflow) begin
                    if (c1.single_shot || c1.reload_select) begin
                        count_reg <= reload_reg;
                    end else begin
                        count_reg <= DTP_CNT_ALL_ONES;
                    end
                end else if (step) begin
                    count_reg <= count_reg - 1'b1;
                end
            end

            // held once a one-shot pass ends; cleared by stop or new reload
            always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
                if (!RST_N_I) begin
                    done_reg <= 1'b0;
                end else if (!c1.run_enable) begin
                    done_reg <= 1'b0;
                end else if (underflow && c1.single_shot) begin
                    done_reg <= 1'b1;
                end else if (RELOAD_WR_I[ch]) begin
                    done_reg <= 1'b0;
                end
            end

            // duty double buffer: taken into use at the frame boundary
            always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
                if (!RST_N_I) begin
                    duty_buf_reg <= DTP_DUTY_RST;
                end else if (DUTY_WR_I[ch]) begin
                    duty_buf_reg <= {high_reg[DUTY_LSB +: 2], WR_DATA_I};
                end
            end

            always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
                if (!RST_N_I) begin
                    duty_act_reg <= DTP_DUTY_RST;
                end else if (underflow) begin
                    duty_act_reg <= duty_buf_reg;
                end
            end

            // set beats a clear arriving in the same cycle
            always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
                if (!RST_N_I) begin
                    flag_reg <= 1'b0;
                end else if (underflow) begin
                    flag_reg <= 1'b1;
                end else if (FLAG_CLEAR_I[ch]) begin
                    flag_reg <= 1'b0;
                end
            end

            // duty above reload would leave the output stuck active
            dtp_wave_out #(
                .CNT_W (CNT_W)
            ) u_wave (
                .clk_i        (REF_CLK_I),
                .rst_n_i      (RST_N_I),
                .count_i      (count_reg),
                .duty_i       (duty_act_reg),
                .run_i        (run),
                .active_low_i (c1.wave_active_low),
                .out_enable_i (c1.wave_out_enable),
                .wave_o       (wave),
                .oe_o         (wave_oe)
            );

            assign flags[ch] = flag_reg;

            assign STATUS_O[ch].count          = count_reg;
            assign STATUS_O[ch].divider_count  = div_count;
            assign STATUS_O[ch].underflow_flag = flag_reg;
            assign STATUS_O[ch].wave           = wave;
            assign STATUS_O[ch].wave_oe        = wave_oe;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // interrupt request and register image

    assign IRQ_REQ_O = GLOBAL_IRQ_ENABLE_I && |(flags & IRQ_ENABLE_I);

    always_comb begin
        IRQ_REG_O                     = 8'h00;
        IRQ_REG_O[DTP_IRQ_EN_POS_A]   = IRQ_ENABLE_I[0];
        IRQ_REG_O[DTP_IRQ_EN_POS_B]   = IRQ_ENABLE_I[NUM_CH-1];
        IRQ_REG_O[DTP_IRQ_FLAG_POS_A] = flags[0];
        IRQ_REG_O[DTP_IRQ_FLAG_POS_B] = flags[NUM_CH-1];
    end

endmodule

// [design/dtp_wave_out.sv]
// pwm compare, polarity and pin drive for one channel
`timescale 1ns/1ns
module dtp_wave_out
    import dtp_pkg::*;
#(
    parameter int CNT_W = DTP_CNT_W
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // compare inputs
    input  wire logic [CNT_W-1:0] count_i,
    input  wire logic [CNT_W-1:0] duty_i,
    input  wire logic             run_i,
    // pin control
    input  wire logic             active_low_i,
    input  wire logic             out_enable_i,
    output logic                  wave_o,
    output logic                  oe_o
);

    logic wave_reg;
    logic oe_reg;
    logic active;

    // active tail of each frame; duty zero never matches
    assign active = run_i && (count_i < duty_i);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wave_reg <= 1'b0;
        end else begin
            wave_reg <= active ^ active_low_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oe_reg <= 1'b0;
        end else begin
            oe_reg <= out_enable_i;
        end
    end

    assign wave_o = wave_reg;
    assign oe_o   = oe_reg;

endmodule

// [test/dtp_ext_pin_model.sv]
// behavioural source for the external count pin
`timescale 1ns/1ns
module dtp_ext_pin_model (
    // clock
    input  wire logic clk_i,
    // pin
    output logic      pin_o
);
    initial pin_o = 1'b0;
    // level held three cycles so each change is one clean edge
    task automatic drive(input logic lvl);
        @(posedge clk_i);
        pin_o <= lvl;
        repeat (3) @(posedge clk_i);
    endtask
endmodule

// [test/dtp_timer_pair_checker.sv]
// port assertions for the dual timer / pwm pair
`timescale 1ns/1ns
module dtp_timer_pair_checker
    import dtp_pkg::*;
#(
    parameter int NUM_CH = DTP_NUM_CH
) (
    // clock, reset and stimulus
    input wire logic                          REF_CLK_I,
    input wire logic                          RST_N_I,
    input wire logic                          HIGH_WR_I,
    input wire logic [7:0]                    HIGH_DATA_I,
    input wire logic [NUM_CH-1:0]             RELOAD_WR_I,
    input wire logic [7:0]                    WR_DATA_I,
    input wire dtp_ctrl_first_t  [NUM_CH-1:0] CTRL_FIRST_I,
    input wire dtp_ctrl_second_t [NUM_CH-1:0] CTRL_SECOND_I,
    input wire logic [NUM_CH-1:0]             IRQ_ENABLE_I,
    input wire logic                          GLOBAL_IRQ_ENABLE_I,
    input wire logic [NUM_CH-1:0]             FLAG_CLEAR_I,
    // design outputs
    input wire dtp_status_t [NUM_CH-1:0]      STATUS_O,
    input wire logic [7:0]                    HIGH_BITS_O,
    input wire logic [7:0]                    IRQ_REG_O,
    input wire logic                          IRQ_REQ_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    logic [1:0] flags;
    logic       fast_a;
    assign flags  = {STATUS_O[1].underflow_flag, STATUS_O[0].underflow_flag};
    // one tick per clock: runs, internal source, divider bypassed, not one-shot
    assign fast_a = CTRL_FIRST_I[0].run_enable && !CTRL_FIRST_I[0].single_shot
                    && !CTRL_SECOND_I[0].source_select && CTRL_SECOND_I[0].divider_enable_n;
    ////////////////////////////////////////////////////////////
    property p_dec; fast_a && STATUS_O[0].count != 10'h000 |=> STATUS_O[0].count == $past(STATUS_O[0].count) - 10'h001; endproperty
    a_dec: assert property (p_dec) else $error("count did not step down");
    property p_wrap; fast_a && !CTRL_FIRST_I[0].reload_select && STATUS_O[0].count == 10'h000
        |=> STATUS_O[0].count == 10'h3FF && STATUS_O[0].underflow_flag; endproperty
    a_wrap: assert property (p_wrap) else $error("no restart from all ones");
    property p_stop; !CTRL_FIRST_I[0].run_enable && !RELOAD_WR_I[0] |=> $stable(STATUS_O[0].count); endproperty
    a_stop: assert property (p_stop) else $error("stopped count moved");
    property p_load; !CTRL_FIRST_I[0].run_enable && RELOAD_WR_I[0]
        |=> STATUS_O[0].count == {$past(HIGH_BITS_O[5:4]), $past(WR_DATA_I)}; endproperty
    a_load: assert property (p_load) else $error("stopped reload write not loaded");
    property p_high; HIGH_WR_I |=> HIGH_BITS_O == $past(HIGH_DATA_I); endproperty
    a_high: assert property (p_high) else $error("high bits not stored");
    property p_flag_hold; STATUS_O[0].underflow_flag && !FLAG_CLEAR_I[0] |=> STATUS_O[0].underflow_flag; endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag cleared by itself");
    property p_irq_req; IRQ_REQ_O == (GLOBAL_IRQ_ENABLE_I && ((flags & IRQ_ENABLE_I[1:0]) != 2'b00)); endproperty
    a_irq_req: assert property (p_irq_req) else $error("request level wrong");
    property p_irq_img; IRQ_REG_O == {2'b00, flags, 2'b00, IRQ_ENABLE_I[1:0]}; endproperty
    a_irq_img: assert property (p_irq_img) else $error("irq image wrong");
    property p_oe; 1'b1 |=> STATUS_O[0].wave_oe == $past(CTRL_FIRST_I[0].wave_out_enable); endproperty
    a_oe: assert property (p_oe) else $error("pin drive not following enable");
    property p_idle; !CTRL_FIRST_I[0].run_enable |=> STATUS_O[0].wave == $past(CTRL_FIRST_I[0].wave_active_low); endproperty
    a_idle: assert property (p_idle) else $error("stopped wave not inactive");
    property p_div; CTRL_SECOND_I[0].divider_enable_n |=> STATUS_O[0].divider_count == 8'h00; endproperty
    a_div: assert property (p_div) else $error("bypassed divider count not clear");
endmodule

bind dtp_timer_pair dtp_timer_pair_checker #(.NUM_CH(NUM_CH)) u_dtp_timer_pair_checker (
    .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .HIGH_WR_I(HIGH_WR_I), .HIGH_DATA_I(HIGH_DATA_I),
    .RELOAD_WR_I(RELOAD_WR_I), .WR_DATA_I(WR_DATA_I), .CTRL_FIRST_I(CTRL_FIRST_I),
    .CTRL_SECOND_I(CTRL_SECOND_I), .IRQ_ENABLE_I(IRQ_ENABLE_I), .GLOBAL_IRQ_ENABLE_I(GLOBAL_IRQ_ENABLE_I),
    .FLAG_CLEAR_I(FLAG_CLEAR_I), .STATUS_O(STATUS_O), .HIGH_BITS_O(HIGH_BITS_O), .IRQ_REG_O(IRQ_REG_O),
    .IRQ_REQ_O(IRQ_REQ_O)
);

// [test/tb_top.sv]
// self-checking bench for the dual timer / pwm pair
`timescale 1ns/1ns
module tb_top;
    import dtp_pkg::*;
    typedef struct {
        string      nm;
        int         sel;
        logic [9:0] ev;
    } dtp_note_t;
    logic                   clk = 1'b0;
    logic                   rst_n = 1'b0;
    logic                   ext_pin;
    logic                   high_wr = 1'b0;
    logic [7:0]             high_data = 8'h00;
    logic [1:0]             reload_wr = 2'b00;
    logic [1:0]             duty_wr = 2'b00;
    logic [7:0]             wr_data = 8'h00;
    dtp_ctrl_first_t  [1:0] ctrl1 = '0;
    dtp_ctrl_second_t [1:0] ctrl2 = '0;
    logic [1:0]             irq_en = 2'b00;
    logic                   global_irq_enable = 1'b0;
    logic [1:0]             flag_clr = 2'b00;
    dtp_status_t      [1:0] status;
    logic [7:0]             high_bits;
    logic                   irq_req;
    dtp_note_t              note_q[$];
    dtp_note_t              n;
    event                   note_ev;
    int                     mismatches = 0;
    int                     samples_checked = 0;
    int                     meas;
    logic [7:0]             rb;

    always #5 clk = ~clk;

    dtp_ext_pin_model u_dtp_ext_pin_model (.clk_i(clk), .pin_o(ext_pin));
    dtp_timer_pair u_dtp_timer_pair (
        .REF_CLK_I(clk), .RST_N_I(rst_n), .EXT_COUNT_I(ext_pin), .HIGH_WR_I(high_wr), .HIGH_DATA_I(high_data),
        .RELOAD_WR_I(reload_wr), .DUTY_WR_I(duty_wr), .WR_DATA_I(wr_data), .CTRL_FIRST_I(ctrl1),
        .CTRL_SECOND_I(ctrl2), .IRQ_ENABLE_I(irq_en), .GLOBAL_IRQ_ENABLE_I(global_irq_enable), .FLAG_CLEAR_I(flag_clr),
        .STATUS_O(status), .HIGH_BITS_O(high_bits), .IRQ_REG_O(), .IRQ_REQ_O(irq_req)
    );
    ////////////////////////////////////////////////////////////
    function automatic logic [9:0] observe(input int sel);
        case (sel)
            0: return status[0].count;
            1: return status[1].count;
            2: return {9'h000, status[0].underflow_flag};
            3: return {9'h000, irq_req};
            4: return {2'b00, high_bits};
            5: return {9'h000, status[0].wave_oe};
            default: return meas[9:0];
        endcase
    endfunction
    task automatic check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // result watcher: oldest note against what the outputs show now
    initial begin
        forever begin
            @(note_ev);
            while (note_q.size() > 0) begin
                n = note_q.pop_front();
                check(n.nm, observe(n.sel), n.ev);
            end
        end
    end
    task automatic note(input string nm, input int sel, input logic [9:0] ev);
        note_q.push_back('{nm, sel, ev});
        ->note_ev;
    endtask
    task automatic expect_val(input string nm, input int sel, input logic [9:0] ev);
        @(negedge clk);
        note(nm, sel, ev);
    endtask
    // kind 0 high register, 1 reload byte, 2 duty byte, 3 flag clear
    task automatic wr(input int kind, input int ch, input logic [7:0] d);
        @(posedge clk);
        high_data <= d;
        wr_data <= d;
        case (kind)
            0: high_wr <= 1'b1;
            1: reload_wr[ch] <= 1'b1;
            2: duty_wr[ch] <= 1'b1;
            default: flag_clr[ch] <= 1'b1;
        endcase
        @(posedge clk);
        high_wr <= 1'b0;
        reload_wr <= 2'b00;
        duty_wr <= 2'b00;
        flag_clr <= 2'b00;
    endtask
    task automatic wait_flag(input int lim);
        int k;
        k = 0;
        while (status[0].underflow_flag !== 1'b1 && k < lim) begin
            @(negedge clk);
            k++;
        end
        check("underflow flag", {9'h000, status[0].underflow_flag}, 10'h001);
    endtask
    task automatic cyc_to_change();
        logic [9:0] c;
        c = status[0].count;
        meas = 0;
        while (status[0].count === c && meas < 600) begin
            @(negedge clk);
            meas++;
        end
    endtask
    // stop, load while stopped, clear flag, then start with new controls
    task automatic run_a(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] rl);
        @(posedge clk);
        ctrl1[0] <= 8'h00;
        wr(1, 0, rl);
        wr(3, 0, 8'h00);
        @(posedge clk);
        ctrl1[0] <= c1;
        ctrl2[0] <= c2;
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #400000;
        mismatches++;
        $display("[ERR] run expected finish seen timeout");
        tally_and_finish();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        meas = $urandom(32'hD889B3FC);
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        expect_val("count a", 0, DTP_COUNT_RST);
        expect_val("high bits", 4, 10'h000);
        $display("test reset done");
        rb = 8'($urandom);
        wr(0, 0, 8'hB0);
        wr(1, 0, 8'h10);
        wr(1, 1, rb);
        expect_val("count a", 0, 10'h310);
        expect_val("count b", 1, {2'b10, rb});
        expect_val("high bits", 4, 10'h0B0);
        $display("test stopped load done");
        wr(0, 0, 8'h00);
        wr(1, 0, 8'h05);
        @(posedge clk);
        irq_en <= 2'b11;
        global_irq_enable <= 1'b1;
        ctrl2[0] <= 8'h07;
        ctrl1[0] <= 8'h03;
        wr(1, 0, 8'h3A);
        expect_val("count a", 0, 10'h005);
        wait_flag(2000);
        note("count a", 0, 10'h03A);
        note("irq req", 3, 10'h001);
        @(posedge clk);
        global_irq_enable <= 1'b0;
        expect_val("irq req", 3, 10'h000);
        wr(3, 0, 8'h00);
        expect_val("flag a", 2, 10'h000);
        for (int r = 0; r < 8; r++) begin
            @(posedge clk);
            ctrl2[0] <= {5'h00, 3'(r)};
            cyc_to_change();
            cyc_to_change();
            expect_val("divider period", 6, 10'(1 << (r + 1)));
        end
        $display("test reload and prescaler done");
        run_a(8'h01, 8'h08, 8'h03);
        wait_flag(20);
        note("count a", 0, 10'h3FF);
        run_a(8'h05, 8'h08, 8'h02);
        wait_flag(20);
        note("count a", 0, 10'h002);
        repeat (4) @(negedge clk);
        expect_val("count a", 0, 10'h002);
        $display("test modes done");
        for (int e = 0; e < 2; e++) begin
            @(posedge clk);
            ctrl1[1] <= 8'h00;
            wr(1, 1, 8'h20);
            @(posedge clk);
            ctrl2[1] <= {3'b001, 1'(e), 4'h8};
            ctrl1[1] <= 8'h01;
            u_dtp_ext_pin_model.drive(1'b1);
            expect_val("count b", 1, (e == 1) ? 10'h020 : 10'h01F);
            u_dtp_ext_pin_model.drive(1'b0);
            expect_val("count b", 1, 10'h01F);
        end
        $display("test external pin done");
        for (int i = 0; i < 4; i++) begin
            wr(2, 0, (i < 2) ? 8'h04 : 8'h00);
            run_a({1'b1, 1'(i), 6'h03}, 8'h08, 8'h09);
            wait_flag(40);
            wr(3, 0, 8'h00);
            meas = 0;
            repeat (40) begin
                @(negedge clk);
                if (status[0].wave !== ctrl1[0].wave_active_low) meas++;
                if (status[0].underflow_flag === 1'b1) break;
            end
            note("active cycles", 6, (i < 2) ? 10'h004 : 10'h000);
            expect_val("wave oe", 5, 10'h001);
        end
        $display("test pwm done");
        // let the watcher drain the last notes before the verdict
        @(negedge clk);
        tally_and_finish();
    end
endmodule
